// file: design/isa_host_register_port.sv
// Purpose: Host bus port with pointer/data access, POST store and value store.
// Assumes: Measurement results arrive as bytes with a write strobe on ref_clk.
// Notes: Host pins pass two flip-flops; strobe edges act after synchronisation.
`timescale 1ns/100ps
module isa_host_register_port #(
  parameter int VALUE_BYTES = 32,
  parameter int RESULT_BYTES = 11
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic bus_clk,
  input wire host_port_pkg::host_ctl_t host_ctl,
  input wire logic [7:0] host_data_in,
  output host_port_pkg::host_drive_t host_drive,
  input wire logic serial_busy_flag,
  input wire logic meas_valid,
  input wire logic [4:0] meas_index,
  input wire logic [7:0] meas_value,
  input wire logic [15:0] limit_event,
  input wire logic [3:0] vid_in,
  input wire logic serial_addr_we,
  input wire logic [6:0] serial_addr_in,
  output logic mgmt_interrupt_out_n,
  output logic nmi_out_n,
  output logic [6:0] serial_addr,
  output logic [3:0] fan_divisor
);
  import host_port_pkg::*;

  host_ctl_t ctl_s1_reg, ctl_s2_reg, ctl_s3_reg;
  logic [7:0] din_s1_reg, din_s2_reg;
  logic busy_s1_reg, busy_s2_reg;
  logic bclk_s1_reg, bclk_s2_reg;
  logic [6:0] ptr_reg, ptr_next;
  logic [4:0] post_wptr_reg, post_wptr_next;
  logic [5:0] post_count_reg, post_count_next;
  logic [4:0] post_rptr_reg, post_rptr_next;
  logic [7:0] post_mem_reg [POST_DEPTH];
  logic [7:0] value_mem_reg [VALUE_BYTES];
  logic [7:0] config_reg, config_next;
  logic [7:0] status1_reg, status1_next, status2_reg, status2_next;
  logic [7:0] smask1_reg, smask1_next, smask2_reg, smask2_next;
  logic [7:0] nmask1_reg, nmask1_next, nmask2_reg, nmask2_next;
  logic [3:0] fandiv_reg, fandiv_next;
  logic [6:0] seraddr_reg, seraddr_next;
  logic [7:0] chiprst_reg, chiprst_next;
  logic [7:0] rdata_reg, rdata_next;
  logic oe_reg, oe_next;
  logic sel, rd_act, wr_start, rd_start, post_wr, data_wr, data_rd, soft_rst;
  logic [7:0] data_rdata;
  logic [15:0] smi_hits, nmi_hits;
  logic post_full, data_acc;
  logic [3:0] vid_s1_reg, vid_s2_reg;

  function automatic logic in_value(input logic [6:0] a);
    in_value = (a[6:5] == VALUE_BASE[6:5]) || (a[6:5] == MIRROR_BASE[6:5]);
  endfunction : in_value

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_s1_reg <= '1;
      ctl_s2_reg <= '1;
      ctl_s3_reg <= '1;
      din_s1_reg <= 8'h00;
      din_s2_reg <= 8'h00;
      busy_s1_reg <= 1'b0;
      busy_s2_reg <= 1'b0;
      bclk_s1_reg <= 1'b0;
      bclk_s2_reg <= 1'b0;
    end else begin
      ctl_s1_reg <= host_ctl;
      ctl_s2_reg <= ctl_s1_reg;
      ctl_s3_reg <= ctl_s2_reg;
      din_s1_reg <= host_data_in;
      din_s2_reg <= din_s1_reg;
      busy_s1_reg <= serial_busy_flag;
      busy_s2_reg <= busy_s1_reg;
      bclk_s1_reg <= bus_clk;
      bclk_s2_reg <= bclk_s1_reg;
    end
  end

  // VID pins are static levels but still pass two flip-flops.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vid_s1_reg <= 4'h0;
      vid_s2_reg <= 4'h0;
    end else begin
      vid_s1_reg <= vid_in;
      vid_s2_reg <= vid_s1_reg;
    end
  end

  // The bus clock is only sampled; all host timing comes from strobe edges.
  assign sel = !ctl_s2_reg.cs_n;
  assign rd_act = sel && !ctl_s2_reg.rd_n;
  assign wr_start = sel && !ctl_s2_reg.wr_n && ctl_s3_reg.wr_n;
  assign rd_start = sel && !ctl_s2_reg.rd_n && ctl_s3_reg.rd_n;
  // Only the three low address bits take part in port selection.
  assign post_wr = wr_start && (ctl_s2_reg.addr == PORT_POST_A || ctl_s2_reg.addr == PORT_POST_B);
  assign data_wr = wr_start && ctl_s2_reg.addr == PORT_DATA && !busy_s2_reg;
  assign data_rd = rd_start && ctl_s2_reg.addr == PORT_DATA && !busy_s2_reg;
  assign soft_rst = data_wr && ptr_reg == ADDR_CHIPRST && din_s2_reg[CHIPRST_BIT];
  assign data_acc = data_wr || data_rd;
  // A full store refuses the write but still raises the overflow flag.
  assign post_full = post_count_reg == 6'(POST_DEPTH);

  always_comb begin
    data_rdata = 8'h00;
    if (ptr_reg[6:5] == POST_BASE[6:5]) begin
      data_rdata = post_mem_reg[post_rptr_reg];
    end else if (in_value(ptr_reg)) begin
      data_rdata = value_mem_reg[ptr_reg[4:0]];
    end else if (ptr_reg == ADDR_CONFIG) begin
      data_rdata = config_reg;
    end else if (ptr_reg == ADDR_STATUS1) begin
      data_rdata = status1_reg;
    end else if (ptr_reg == ADDR_STATUS2) begin
      data_rdata = status2_reg;
    end else if (ptr_reg == ADDR_SMASK1) begin
      data_rdata = smask1_reg;
    end else if (ptr_reg == ADDR_SMASK2) begin
      data_rdata = smask2_reg;
    end else if (ptr_reg == ADDR_NMASK1) begin
      data_rdata = nmask1_reg;
    end else if (ptr_reg == ADDR_NMASK2) begin
      data_rdata = nmask2_reg;
    end else if (ptr_reg == ADDR_FANDIV) begin
      data_rdata = {fandiv_reg, vid_s2_reg};
    end else if (ptr_reg == ADDR_SERADDR) begin
      data_rdata = {1'b0, seraddr_reg};
    end else if (ptr_reg == ADDR_CHIPRST) begin
      data_rdata = chiprst_reg;
    end
  end

  always_comb begin
    rdata_next = rdata_reg;
    oe_next = rd_act;
    if (rd_start && ctl_s2_reg.addr == PORT_POINTER) begin
      rdata_next = {busy_s2_reg, ptr_reg};
    end else if (rd_start) begin
      rdata_next = data_rdata;
    end
  end

  always_comb begin
    ptr_next = ptr_reg;
    post_rptr_next = post_rptr_reg;
    if (wr_start && ctl_s2_reg.addr == PORT_POINTER && !busy_s2_reg) begin
      ptr_next = din_s2_reg[6:0];
      post_rptr_next = din_s2_reg[4:0];
    end else if (data_acc && ptr_reg[6:5] == MIRROR_BASE[6:5] && ptr_reg != MIRROR_LAST) begin
      ptr_next = ptr_reg + 7'd1;
    end else if (data_acc && ptr_reg[6:5] == POST_BASE[6:5] && post_rptr_reg != POST_LAST) begin
      post_rptr_next = post_rptr_reg + 5'd1;
    end
  end

  always_comb begin
    post_wptr_next = post_wptr_reg;
    post_count_next = post_count_reg;
    if (post_wr && !post_full) begin
      post_count_next = post_count_reg + 6'd1;
      if (post_wptr_reg != POST_LAST) begin
        post_wptr_next = post_wptr_reg + 5'd1;
      end
    end
  end

  always_comb begin
    config_next = config_reg;
    smask1_next = smask1_reg;
    smask2_next = smask2_reg;
    nmask1_next = nmask1_reg;
    nmask2_next = nmask2_reg;
    fandiv_next = fandiv_reg;
    seraddr_next = seraddr_reg;
    chiprst_next = chiprst_reg;
    status1_next = status1_reg;
    status2_next = status2_reg;
    if (data_wr && ptr_reg == ADDR_CONFIG) begin
      config_next = din_s2_reg;
    end
    if (data_wr && ptr_reg == ADDR_SMASK1) begin
      smask1_next = din_s2_reg;
    end
    if (data_wr && ptr_reg == ADDR_SMASK2) begin
      smask2_next = din_s2_reg;
    end
    if (data_wr && ptr_reg == ADDR_NMASK1) begin
      nmask1_next = din_s2_reg;
    end
    if (data_wr && ptr_reg == ADDR_NMASK2) begin
      nmask2_next = din_s2_reg;
    end
    if (data_wr && ptr_reg == ADDR_FANDIV) begin
      fandiv_next = din_s2_reg[7:4];
    end
    if (data_wr && ptr_reg == ADDR_SERADDR) begin
      seraddr_next = din_s2_reg[6:0];
    end
    if (serial_addr_we) begin
      seraddr_next = serial_addr_in;
    end
    if (data_rd && ptr_reg == ADDR_STATUS1) begin
      status1_next = 8'h00;
    end
    if (data_rd && ptr_reg == ADDR_STATUS2) begin
      status2_next = 8'h00;
    end
    // Events set after any clear so that a simultaneous event is kept.
    status1_next = status1_next | limit_event[7:0];
    status2_next = status2_next | limit_event[15:8];
    if (post_wr && post_full) begin
      status2_next[POST_OVF_BIT] = 1'b1;
    end
    if (soft_rst) begin
      config_next = RST_CONFIG;
      smask1_next = RST_ZERO;
      smask2_next = RST_ZERO;
      nmask1_next = RST_ZERO;
      nmask2_next = RST_NMASK2;
      fandiv_next = RST_FANDIV;
      seraddr_next = RST_SERADDR;
      chiprst_next = RST_CHIPRST;
      status1_next = limit_event[7:0];
      status2_next = limit_event[15:8];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_reg <= 7'h00;
      post_rptr_reg <= 5'h00;
      post_wptr_reg <= 5'h00;
      post_count_reg <= 6'h00;
      rdata_reg <= 8'h00;
      oe_reg <= 1'b0;
      config_reg <= RST_CONFIG;
      status1_reg <= RST_ZERO;
      status2_reg <= RST_ZERO;
      smask1_reg <= RST_ZERO;
      smask2_reg <= RST_ZERO;
      nmask1_reg <= RST_ZERO;
      nmask2_reg <= RST_NMASK2;
      fandiv_reg <= RST_FANDIV;
      seraddr_reg <= RST_SERADDR;
      chiprst_reg <= RST_CHIPRST;
    end else begin
      ptr_reg <= ptr_next;
      post_rptr_reg <= post_rptr_next;
      post_wptr_reg <= post_wptr_next;
      post_count_reg <= post_count_next;
      rdata_reg <= rdata_next;
      oe_reg <= oe_next;
      config_reg <= config_next;
      status1_reg <= status1_next;
      status2_reg <= status2_next;
      smask1_reg <= smask1_next;
      smask2_reg <= smask2_next;
      nmask1_reg <= nmask1_next;
      nmask2_reg <= nmask2_next;
      fandiv_reg <= fandiv_next;
      seraddr_reg <= seraddr_next;
      chiprst_reg <= chiprst_next;
    end
  end

  // Storage has no reset; contents start indeterminate.
  always_ff @(posedge ref_clk) begin
    if (post_wr && !post_full) begin
      post_mem_reg[post_wptr_reg] <= din_s2_reg;
    end
  end

  // Results are stored as given: voltage, temperature and fan codes.
  generate
    for (genvar i = 0; i < VALUE_BYTES; i++) begin : g_value
      always_ff @(posedge ref_clk) begin
        if (data_wr && in_value(ptr_reg) && ptr_reg[4:0] == 5'(i)) begin
          value_mem_reg[i] <= din_s2_reg;
        end else if (meas_valid && meas_index == 5'(i) && i < RESULT_BYTES) begin
          value_mem_reg[i] <= meas_value;
        end
      end
    end
  endgenerate

  assign smi_hits = {status2_reg & smask2_reg, status1_reg & smask1_reg};
  assign nmi_hits = {status2_reg & nmask2_reg, status1_reg & nmask1_reg};
  assign mgmt_interrupt_out_n = !(config_reg[CFG_SMI_EN_BIT] && |smi_hits);
  assign nmi_out_n = !(config_reg[CFG_NMI_EN_BIT] && |nmi_hits);
  assign host_drive = '{data: rdata_reg, oe: oe_reg};
  assign serial_addr = seraddr_reg;
  assign fan_divisor = fandiv_reg;
endmodule : isa_host_register_port

// file: design/host_port_pkg.sv
// Purpose: Constants and types for the parallel host register port.
// Assumes: Host strobes and the bus clock arrive asynchronous to ref_clk.
package host_port_pkg;
  localparam logic [2:0] PORT_POST_A = 3'h0;
  localparam logic [2:0] PORT_POST_B = 3'h4;
  localparam logic [2:0] PORT_POINTER = 3'h5;
  localparam logic [2:0] PORT_DATA = 3'h6;
  localparam int POST_DEPTH = 32;
  localparam logic [4:0] POST_LAST = 5'h1F;
  localparam logic [6:0] POST_BASE = 7'h00;
  localparam logic [6:0] VALUE_BASE = 7'h20;
  localparam logic [6:0] MIRROR_BASE = 7'h60;
  localparam logic [6:0] MIRROR_LAST = 7'h7F;
  localparam logic [6:0] ADDR_CONFIG = 7'h40;
  localparam logic [6:0] ADDR_STATUS1 = 7'h41;
  localparam logic [6:0] ADDR_STATUS2 = 7'h42;
  localparam logic [6:0] ADDR_SMASK1 = 7'h43;
  localparam logic [6:0] ADDR_SMASK2 = 7'h44;
  localparam logic [6:0] ADDR_NMASK1 = 7'h45;
  localparam logic [6:0] ADDR_NMASK2 = 7'h46;
  localparam logic [6:0] ADDR_FANDIV = 7'h47;
  localparam logic [6:0] ADDR_SERADDR = 7'h48;
  localparam logic [6:0] ADDR_CHIPRST = 7'h49;
  localparam logic [7:0] RST_CONFIG = 8'h08;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_NMASK2 = 8'h40;
  localparam logic [3:0] RST_FANDIV = 4'h5;
  localparam logic [6:0] RST_SERADDR = 7'h2D;
  localparam logic [7:0] RST_CHIPRST = 8'h40;
  localparam int CHIPRST_BIT = 7;
  localparam int CFG_SMI_EN_BIT = 1;
  localparam int CFG_NMI_EN_BIT = 2;
  localparam int POST_OVF_BIT = 6;
  localparam int BUSY_BIT = 7;
  localparam logic [7:0] FAN_FULL = 8'hFF;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [2:0] addr;
  } host_ctl_t;

  typedef struct packed {
    logic [7:0] data;
    logic oe;
  } host_drive_t;
endpackage : host_port_pkg

// file: testbench/isa_host_model.sv
// Purpose: Host processor model that drives the parallel port pins.
// Assumes: Each transfer starts at a falling ref_clk edge.
// Notes: Released data lines show the inverse of the last value.
`timescale 1ns/100ps
module isa_host_model (
  input wire logic ref_clk,
  output logic bus_clk,
  output host_port_pkg::host_ctl_t ctl,
  output logic [7:0] wdata,
  input wire host_port_pkg::host_drive_t drv
);
  import host_port_pkg::*;
  initial begin
    bus_clk = 1'b0;
    ctl = '{1'b1, 1'b1, 1'b1, 3'h0};
    wdata = 8'h00;
  end
  always #62.5 bus_clk = ~bus_clk;
  // One transfer; q is all unknown when no answer comes.
  task automatic xfer(input logic rd, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(negedge ref_clk);
    ctl = '{1'b0, 1'b1, 1'b1, a};
    wdata = d;
    @(negedge ref_clk);
    ctl = '{1'b0, !rd, rd, a};
    n = 0;
    q = 8'hXX;
    while (n < 20 && (n < 4 || (rd && !drv.oe))) begin
      @(negedge ref_clk);
      n++;
    end
    if (!rd || drv.oe) begin
      q = drv.data;
    end
    ctl = '{1'b0, 1'b1, 1'b1, a};
    @(negedge ref_clk);
    ctl = '{1'b1, 1'b1, 1'b1, a};
    wdata = ~d;
    repeat (4) @(negedge ref_clk);
  endtask : xfer
endmodule : isa_host_model

// file: testbench/isa_host_register_port_properties.sv
// Purpose: Port-level properties of the host register port.
// Assumes: Host strobes stay low at least four cycles.
// Notes: Attached to every instance of the port.
`timescale 1ns/100ps
module host_port_checker (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire host_port_pkg::host_ctl_t host_ctl,
  input wire host_port_pkg::host_drive_t host_drive,
  input wire logic serial_busy_flag,
  input wire logic serial_addr_we,
  input wire logic [6:0] serial_addr_in,
  input wire logic [6:0] serial_addr,
  input wire logic [3:0] fan_divisor
);
  import host_port_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  oe_cause_a: assert property ($rose(host_drive.oe) |-> !$past(host_ctl.rd_n, 2) && !host_ctl.rd_n)
    else $error("drive enable rose without a read strobe");
  read_answer_a: assert property ($fell(host_ctl.rd_n) && !host_ctl.cs_n && !serial_busy_flag
    |-> ##[2:4] host_drive.oe)
    else $error("read strobe got no answer");
  oe_release_a: assert property ($rose(host_ctl.rd_n) |-> ##[1:4] !host_drive.oe)
    else $error("drive enable outlived the read strobe");
  oe_idle_a: assert property (host_ctl.rd_n [*5] |-> !host_drive.oe)
    else $error("bus driven with no read strobe");
  data_hold_a: assert property (host_drive.oe && $past(host_drive.oe) |-> $stable(host_drive.data))
    else $error("read data changed while driven");
  ser_load_a: assert property (serial_addr_we |=> serial_addr == $past(serial_addr_in))
    else $error("serial address not loaded from serial side");
  ser_hold_a: assert property ((host_ctl.wr_n && !serial_addr_we) [*6] |=> $stable(serial_addr))
    else $error("serial address changed with no write");
  fan_hold_a: assert property (host_ctl.wr_n [*6] |=> $stable(fan_divisor))
    else $error("fan divisor changed with no write");
  cover property ($rose(host_drive.oe));
  cover property (serial_addr_we);
  cover property ($fell(host_ctl.wr_n) && host_ctl.addr == PORT_POST_B);
endmodule : host_port_checker
bind isa_host_register_port host_port_checker chk (.ref_clk, .rst_b, .host_ctl, .host_drive,
  .serial_busy_flag, .serial_addr_we, .serial_addr_in, .serial_addr, .fan_divisor);

// file: testbench/tb_isa_host_register_port.sv
// Purpose: Self-checking bench for the host register port.
// Assumes: Host transfers go through the host model.
// Notes: Expected values come from the register map.
`timescale 1ns/100ps
module tb_isa_host_register_port;
  import host_port_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic bus_clk, serial_busy_flag = 1'b0, meas_valid = 1'b0, serial_addr_we = 1'b0;
  logic [4:0] meas_index = 5'h00;
  logic [7:0] meas_value = 8'h00, host_data_in, q;
  logic [15:0] limit_event = 16'h0000;
  logic [3:0] vid_in = 4'hA, fan_divisor;
  logic [6:0] serial_addr_in = 7'h00, serial_addr;
  logic mgmt_interrupt_out_n, nmi_out_n;
  host_ctl_t host_ctl;
  host_drive_t host_drive;
  int n_fail = 0;
  int n_compared = 0;
  always #2 ref_clk = ~ref_clk;
  isa_host_register_port dut (.ref_clk(ref_clk), .rst_b(rst_b), .bus_clk(bus_clk), .host_ctl(host_ctl),
    .host_data_in(host_data_in), .host_drive(host_drive), .serial_busy_flag(serial_busy_flag),
    .meas_valid(meas_valid), .meas_index(meas_index), .meas_value(meas_value), .limit_event(limit_event),
    .vid_in(vid_in), .serial_addr_we(serial_addr_we), .serial_addr_in(serial_addr_in),
    .mgmt_interrupt_out_n(mgmt_interrupt_out_n), .nmi_out_n(nmi_out_n), .serial_addr(serial_addr),
    .fan_divisor(fan_divisor));
  isa_host_model host (.ref_clk, .bus_clk, .ctl(host_ctl), .wdata(host_data_in), .drv(host_drive));
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string w);
    host.xfer(1'b1, a, 8'h00, q);
    check(w, q, e);
    if (q === 8'hXX) begin
      finish_test();
    end
  endtask : rd
  task automatic reg_rd(input logic [7:0] p, input logic [7:0] e, input string w);
    wr(3'h5, p);
    rd(3'h6, e, w);
  endtask : reg_rd
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    rst_b = 1'b1;
    check("serial addr", {1'b0, serial_addr}, 8'h2D);
    check("fan divisor", {4'h0, fan_divisor}, 8'h05);
    reg_rd(8'h40, 8'h08, "config");
    wr(3'h5, 8'hC8);
    rd(3'h5, 8'h48, "pointer bit7");
    rd(3'h6, 8'h2D, "serial reg");
    rd(3'h5, 8'h48, "pointer kept");
    wr(3'h6, 8'h33);
    check("serial load", {1'b0, serial_addr}, 8'h33);
    reg_rd(8'h47, 8'h5A, "vid fan");
    serial_addr_we = 1'b1;
    serial_addr_in = 7'h11;
    @(negedge ref_clk);
    serial_addr_we = 1'b0;
    reg_rd(8'h48, 8'h11, "serial side");
    serial_busy_flag = 1'b1;
    wr(3'h5, 8'h40);
    rd(3'h5, 8'hC8, "busy pointer");
    serial_busy_flag = 1'b0;
    wr(3'h5, 8'h49);
    wr(3'h6, 8'h80);
    check("soft reset", {1'b0, serial_addr}, 8'h2D);
    $display("end test registers");
    wr(3'h5, 8'h60);
    wr(3'h6, 8'hA5);
    wr(3'h6, 8'h5A);
    rd(3'h5, 8'h62, "mirror step");
    reg_rd(8'h21, 8'h5A, "alias");
    rd(3'h5, 8'h21, "low no step");
    wr(3'h1, 8'h55);
    rd(3'h5, 8'h21, "unmapped port");
    meas_index = 5'h03;
    meas_value = 8'h77;
    meas_valid = 1'b1;
    @(negedge ref_clk);
    meas_valid = 1'b0;
    reg_rd(8'h63, 8'h77, "result");
    wr(3'h5, 8'h7F);
    wr(3'h6, 8'h3C);
    rd(3'h5, 8'h7F, "mirror top");
    reg_rd(8'h3F, 8'h3C, "top alias");
    limit_event = 16'h0101;
    @(negedge ref_clk);
    limit_event = 16'h0000;
    reg_rd(8'h41, 8'h01, "status1");
    reg_rd(8'h42, 8'h01, "status2");
    reg_rd(8'h41, 8'h00, "status clear");
    wr(3'h5, 8'h43);
    wr(3'h6, 8'h01);
    wr(3'h5, 8'h45);
    wr(3'h6, 8'h01);
    wr(3'h5, 8'h40);
    wr(3'h6, 8'h0E);
    check("smi idle", {7'h00, mgmt_interrupt_out_n}, 8'h01);
    check("nmi idle", {7'h00, nmi_out_n}, 8'h01);
    limit_event = 16'h0001;
    @(negedge ref_clk);
    limit_event = 16'h0000;
    check("smi active", {7'h00, mgmt_interrupt_out_n}, 8'h00);
    check("nmi active", {7'h00, nmi_out_n}, 8'h00);
    reg_rd(8'h41, 8'h01, "status irq");
    check("smi released", {7'h00, mgmt_interrupt_out_n}, 8'h01);
    check("nmi released", {7'h00, nmi_out_n}, 8'h01);
    $display("end test value store");
    for (int i = 0; i < 32; i++) wr(i[0] ? PORT_POST_B : PORT_POST_A, 8'(i + 16));
    reg_rd(8'h42, 8'h00, "no overflow");
    wr(3'h0, 8'hEE);
    check("nmi overflow", {7'h00, nmi_out_n}, 8'h00);
    reg_rd(8'h42, 8'h40, "overflow");
    check("nmi cleared", {7'h00, nmi_out_n}, 8'h01);
    wr(3'h5, 8'h00);
    for (int i = 0; i < 33; i++) rd(3'h6, 8'((i > 31 ? 31 : i) + 16), "post");
    $display("end test post store");
    finish_test();
  end
endmodule : tb_isa_host_register_port
